// ==== src/window_port_map.vh ====
// Register offsets, field positions, reset values and size codes for the window port
`ifndef WINDOW_PORT_MAP_VH
`define WINDOW_PORT_MAP_VH

// APB byte offsets
`define OFF_OUT_BUF      12'h000
`define OFF_IN_BUF       12'h004
`define OFF_DISP         12'h008
`define OFF_RELOC        12'h00c
`define OFF_BASE         12'h010
`define OFF_VECTOR       12'h014
`define OFF_CTRL         12'h018
`define OFF_STATUS       12'h01c
`define OFF_MASK         12'h020
`define OFF_TARGET       12'h024

// Control register fields
`define CTRL_PASS_BIT    0
`define CTRL_ORIG_BIT    1
`define CTRL_ERRCLR_BIT  2

// Status / mask fields
`define ST_CAPTURE_BIT   0
`define ST_ERROR_BIT     1
`define ST_MSG_BIT       2

// Reset values
`define RST_WORD16       16'h0000
`define RST_CTRL         2'h0
`define RST_IRQ          3'h0

// Window size codes: 0 = half-K words ... 6 = 32K words
`define SIZE_MAX         3'h6
`define DEC_LOW_BASE     10

// Field limits
`define BASE_FIELD_LSB   8
`define VEC_FIELD_MSB    9
`define VEC_FIELD_LSB    2
`define RELOC_SHIFT      2

`endif

// ==== src/window_word_store.v ====
// Two-word storage, used for the local data buffer plus a spare word, registered read
`timescale 1ns/1ps
`include "window_port_map.vh"
module window_word_store (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Write port
    input  wire        wr_en,
    input  wire        wr_sel,
    input  wire [15:0] wr_data,
    // Read port
    input  wire        rd_sel,
    output reg  [15:0] rd_data
);

    reg [15:0] word_r [0:1];
    integer    i;

    // Both words cleared by bus initialize
    always @(posedge mclk) begin
        if (!rst_n) begin
            for (i = 0; i < 2; i = i + 1)
                word_r[i] <= `RST_WORD16;
            rd_data <= `RST_WORD16;
        end else begin
            if (wr_en)
                word_r[wr_sel] <= wr_data;
            rd_data <= word_r[rd_sel];
        end
    end

endmodule // window_word_store

// ==== src/window_decoder.v ====
// Window compare and displacement mask for a selected window size
`timescale 1ns/1ps
`include "window_port_map.vh"
module window_decoder (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Configuration and address
    input  wire [2:0]  win_size,
    input  wire [7:0]  win_base,
    input  wire [17:0] orig_addr,
    input  wire        addr_valid,
    // Results
    output reg         match_r,
    output reg  [15:0] disp_r,
    output reg  [15:0] disp_mask_r
);

    reg [17:0] hi_mask;
    reg [17:0] base_full;
    reg [15:0] low_mask;

    // Boundary moves up one bit per doubling
    always @* begin
        low_mask  = 16'h03ff;
        if (win_size <= `SIZE_MAX)
            low_mask = (16'h03ff << win_size) | 16'h03ff;
        hi_mask   = ~{2'b00, low_mask};
        base_full = {win_base, 10'h000};
    end

    // Registered compare of bits 17:N against the base
    always @(posedge mclk) begin
        if (!rst_n) begin
            match_r     <= 1'b0;
            disp_r      <= `RST_WORD16;
            disp_mask_r <= 16'h03ff;
        end else begin
            match_r     <= addr_valid &&
                           ((orig_addr & hi_mask) == (base_full & hi_mask));
            disp_r      <= orig_addr[15:0] & low_mask;
            disp_mask_r <= low_mask;
        end
    end

endmodule // window_decoder

// ==== src/window_port_regs.v ====
// Per-port register set of a two-bus address window, APB slave
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "window_port_map.vh"
module window_port_regs (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Jumper straps (static pins)
    input  wire [2:0]  win_size_pin,
    input  wire [7:0]  win_base_pin,
    input  wire [7:0]  vector_pin,
    // Originator bus window cycle
    input  wire [17:0] orig_addr,
    input  wire        orig_valid,
    input  wire        orig_write,
    input  wire        orig_byte,
    input  wire [15:0] orig_wdata,
    input  wire        access_error,
    // Far port view
    input  wire [15:0] far_buf,
    input  wire [15:0] far_disp,
    input  wire [2:0]  far_size,
    // Target bus master side
    input  wire        target_master,
    input  wire        intr_cycle,
    output reg  [17:0] target_addr,
    output reg  [15:0] vector_out,
    output reg  [15:0] local_buf,
    output reg  [15:0] disp_out,
    // Interrupt
    output reg         irq
);

    // Pin synchronisers (jumpers and cycle strobes come from outside)
    reg [2:0]  size_s1_r, size_r;
    reg [7:0]  base_s1_r, base_r;
    reg [7:0]  vec_s1_r,  vec_r;
    reg [2:0]  fsize_s1_r, fsize_r;
    reg [17:0] addr_s1_r, addr_r;
    reg [3:0]  cyc_s1_r, cyc_r;
    reg [15:0] wd_s1_r, wd_r;
    reg        err_s1_r, err_r;
    reg        tm_s1_r, tm_r;
    reg        ic_s1_r, ic_r;
    reg [15:0] fbuf_s1_r, fbuf_r;
    reg [15:0] fdisp_s1_r, fdisp_r;

    always @(posedge mclk) begin
        if (!rst_n) begin
            size_s1_r <= 3'h0;  size_r <= 3'h0;
            base_s1_r <= 8'h00; base_r <= 8'h00;
            vec_s1_r  <= 8'h00; vec_r  <= 8'h00;
            fsize_s1_r <= 3'h0; fsize_r <= 3'h0;
            addr_s1_r <= 18'h00000; addr_r <= 18'h00000;
            cyc_s1_r  <= 4'h0;  cyc_r  <= 4'h0;
            wd_s1_r   <= 16'h0000; wd_r <= 16'h0000;
            err_s1_r  <= 1'b0;  err_r  <= 1'b0;
            tm_s1_r   <= 1'b0;  tm_r   <= 1'b0;
            ic_s1_r   <= 1'b0;  ic_r   <= 1'b0;
            fbuf_s1_r <= 16'h0000; fbuf_r <= 16'h0000;
            fdisp_s1_r <= 16'h0000; fdisp_r <= 16'h0000;
        end else begin
            size_s1_r <= win_size_pin;  size_r <= size_s1_r;
            base_s1_r <= win_base_pin;  base_r <= base_s1_r;
            vec_s1_r  <= vector_pin;    vec_r  <= vec_s1_r;
            fsize_s1_r <= far_size;     fsize_r <= fsize_s1_r;
            addr_s1_r <= orig_addr;     addr_r <= addr_s1_r;
            cyc_s1_r  <= {orig_valid, orig_write, orig_byte, 1'b0};
            cyc_r     <= cyc_s1_r;
            wd_s1_r   <= orig_wdata;    wd_r <= wd_s1_r;
            err_s1_r  <= access_error;  err_r <= err_s1_r;
            tm_s1_r   <= target_master; tm_r <= tm_s1_r;
            ic_s1_r   <= intr_cycle;    ic_r <= ic_s1_r;
            fbuf_s1_r <= far_buf;       fbuf_r <= fbuf_s1_r;
            fdisp_s1_r <= far_disp;     fdisp_r <= fdisp_s1_r;
        end
    end

    // Far words come from the other bus with no qualifier: a word is
    // taken only when two samples in a row agree, so a value caught
    // while its bits were still changing never reaches a register
    // read or the target address. Costs two cycles of latency.
    reg [15:0] fbuf_q_r,  fbuf_ok_r;
    reg [15:0] fdisp_q_r, fdisp_ok_r;

    always @(posedge mclk) begin
        if (!rst_n) begin
            fbuf_q_r   <= `RST_WORD16;
            fbuf_ok_r  <= `RST_WORD16;
            fdisp_q_r  <= `RST_WORD16;
            fdisp_ok_r <= `RST_WORD16;
        end else begin
            fbuf_q_r  <= fbuf_r;
            fdisp_q_r <= fdisp_r;
            // Hold the last settled word while samples disagree
            if (fbuf_r == fbuf_q_r)
                fbuf_ok_r <= fbuf_r;
            if (fdisp_r == fdisp_q_r)
                fdisp_ok_r <= fdisp_r;
        end
    end

    // Relocation field mask for a window size code
    function [15:0] reloc_mask;
        input [2:0] sz;
        begin
            if (sz <= `SIZE_MAX)
                reloc_mask = 16'hff00 << sz;
            else
                reloc_mask = 16'hff00;
        end
    endfunction

    // APB decode
    wire       acc    = psel && penable;
    wire       wr_acc = acc && pwrite;
    wire       rd_acc = acc && !pwrite;
    wire [15:0] wdat  = pwdata[15:0];

    // Control and state
    reg  [1:0]  ctrl_r;
    reg  [15:0] disp_r;
    reg  [15:0] reloc_r;
    reg         blocked_r;
    reg  [2:0]  status_r;
    reg  [2:0]  mask_r;
    reg  [2:0]  status_nxt;
    reg         cyc_d_r;

    wire pass_on  = ctrl_r[`CTRL_PASS_BIT];
    wire is_orig  = ctrl_r[`CTRL_ORIG_BIT];

    // Decoder on the originator address
    wire        dec_match;
    wire [15:0] dec_disp;
    wire [15:0] dec_mask;

    window_decoder u_dec (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .win_size    (size_r),
        .win_base    (base_r),
        .orig_addr   (addr_r),
        .addr_valid  (cyc_r[3] && is_orig && pass_on),
        .match_r     (dec_match),
        .disp_r      (dec_disp),
        .disp_mask_r (dec_mask)
    );

    // One pulse per originator cycle, delayed to align with decoder
    reg  cyc_q_r;
    reg  [15:0] wd_q_r;
    reg  wr_q_r;
    wire cyc_event = dec_match && cyc_q_r && !cyc_d_r;

    always @(posedge mclk) begin
        if (!rst_n) begin
            cyc_q_r <= 1'b0;
            cyc_d_r <= 1'b0;
            wd_q_r  <= 16'h0000;
            wr_q_r  <= 1'b0;
        end else begin
            cyc_q_r <= cyc_r[3];
            cyc_d_r <= cyc_q_r;
            wd_q_r  <= wd_r;
            wr_q_r  <= cyc_r[2];
        end
    end

    // Window capture while the window is open. The access that raises
    // the error is still latched, so software can find the failing
    // displacement; later accesses are refused until the block is
    // cleared. The error pin passes two flip-flops, one fewer than the
    // cycle strobe, so the error arrives here one cycle ahead of it.
    wire capture = cyc_event && !blocked_r;

    // Data buffer write selection
    wire sw_buf_wr = wr_acc && (paddr == `OFF_OUT_BUF) &&
                     !(pass_on && is_orig);
    // A failing access leaves the buffer as it was
    wire hw_buf_wr = capture && wr_q_r && !err_r;
    wire [15:0] buf_wdata = hw_buf_wr ? wd_q_r : wdat;

    // Local buffer in word 0; word 1 unused spare
    wire [15:0] store_rd;

    window_word_store u_store (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .wr_en   (hw_buf_wr || sw_buf_wr),
        .wr_sel  (1'b0),
        .wr_data (buf_wdata),
        .rd_sel  (1'b0),
        .rd_data (store_rd)
    );

    // Control, displacement, relocation and error block
    always @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_r    <= `RST_CTRL;
            disp_r    <= `RST_WORD16;
            reloc_r   <= `RST_WORD16;
            blocked_r <= 1'b0;
            mask_r    <= `RST_IRQ;
        end else begin
            if (wr_acc && paddr == `OFF_CTRL)
                ctrl_r <= wdat[1:0];
            if (wr_acc && paddr == `OFF_MASK)
                mask_r <= wdat[2:0];
            // Relocation length follows the far window decoder
            if (wr_acc && paddr == `OFF_RELOC)
                reloc_r <= wdat & reloc_mask(fsize_r);
            // Error freezes the window until software clears it
            if (err_r && cyc_q_r)
                blocked_r <= 1'b1;
            else if (wr_acc && paddr == `OFF_CTRL && wdat[`CTRL_ERRCLR_BIT])
                blocked_r <= 1'b0;
            // Only hardware loads the displacement
            if (capture)
                disp_r <= dec_disp & dec_mask;
        end
    end

    // Sticky status: set wins over read-clear
    wire rd_status = rd_acc && paddr == `OFF_STATUS;
    wire msg_event = wr_acc && paddr == `OFF_OUT_BUF && sw_buf_wr;

    always @* begin
        status_nxt = rd_status ? 3'h0 : status_r;
        if (capture)
            status_nxt[`ST_CAPTURE_BIT] = 1'b1;
        if (err_r && cyc_q_r && !blocked_r)
            status_nxt[`ST_ERROR_BIT] = 1'b1;
        if (msg_event)
            status_nxt[`ST_MSG_BIT] = 1'b1;
    end

    always @(posedge mclk) begin
        if (!rst_n)
            status_r <= `RST_IRQ;
        else
            status_r <= status_nxt;
    end

    // Target address: far relocation bit k gives address bit k+2
    wire [15:0] far_rmask = reloc_mask(fsize_r);
    wire [17:0] far_hi = {reloc_r, 2'b00} & {far_rmask, 2'b00};
    // Displacement fills every address bit below the relocation field
    wire [17:0] far_lo = {2'b00, fdisp_ok_r} & ~{far_rmask, 2'b00};

    // Read mux. Status shows its next value: an event that lands at
    // the setup edge is returned now and cleared at the access edge,
    // instead of being cleared unseen.
    reg [15:0] rd_mux;
    reg        rd_ok;

    always @* begin
        rd_ok  = 1'b1;
        rd_mux = 16'h0000;
        case (paddr)
            `OFF_OUT_BUF: rd_mux = store_rd;
            `OFF_IN_BUF:  rd_mux = fbuf_ok_r;
            `OFF_DISP:    rd_mux = disp_r;
            `OFF_RELOC:   rd_mux = reloc_r & reloc_mask(fsize_r);
            `OFF_BASE:    rd_mux = {base_r, 8'h00};
            `OFF_VECTOR:  rd_mux = {6'h00, vec_r, 2'b00};
            `OFF_CTRL:    rd_mux = {13'h0000, blocked_r, ctrl_r};
            `OFF_STATUS:  rd_mux = {13'h0000, status_nxt};
            `OFF_MASK:    rd_mux = {13'h0000, mask_r};
            `OFF_TARGET:  rd_mux = target_addr[15:0];
            default:      rd_ok  = 1'b0;
        endcase
    end

    // APB answer: one-cycle access phase, error on unmapped address.
    // Read data is taken at the setup edge and stands for the whole
    // access cycle; there are no wait states.
    always @(posedge mclk) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_ok;
            if (psel && !penable && !pwrite)
                prdata <= {16'h0000, rd_mux};
        end
    end

    // Target bus drive and exported views
    always @(posedge mclk) begin
        if (!rst_n) begin
            target_addr <= 18'h00000;
            vector_out  <= 16'h0000;
            local_buf   <= 16'h0000;
            disp_out    <= 16'h0000;
            irq         <= 1'b0;
        end else begin
            // Relocation high bits plus far displacement
            if (tm_r)
                target_addr <= far_hi | far_lo;
            vector_out  <= ic_r ? {6'h00, vec_r, 2'b00} : 16'h0000;
            local_buf   <= store_rd;
            disp_out    <= disp_r;
            // Next status, so the line drops with the clearing read
            irq         <= |(status_nxt & mask_r);
        end
    end

endmodule // window_port_regs

// ==== test/far_port_model.sv ====
// Behavioural model of the opposite port's registers
`timescale 1ns/1ps
module far_port_model #(
    parameter [2:0] FAR_SIZE = 3'h2
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Far processor activity
    input  wire        load_msg,
    input  wire [15:0] msg_data,
    input  wire        load_disp,
    input  wire [15:0] disp_data,
    // View seen by the port under test
    output reg  [15:0] far_buf,
    output reg  [15:0] far_disp,
    output wire [2:0]  far_size
);
    assign far_size = FAR_SIZE;
    // Far buffer and displacement, cleared by init
    always @(posedge mclk) begin
        if (!rst_n) begin
            far_buf  <= 16'h0000;
            far_disp <= 16'h0000;
        end else begin
            if (load_msg)
                far_buf <= msg_data;
            // Only the low bits below the decoder exist
            if (load_disp)
                far_disp <= disp_data & ((16'h0400 << FAR_SIZE) - 16'h0001);
        end
    end
endmodule // far_port_model

// ==== test/window_port_monitor.sv ====
// Concurrent checks on the window port register set
`timescale 1ns/1ps
`include "window_port_map.vh"
module window_port_monitor (
    // Clock and reset
    input wire        mclk,
    input wire        rst_n,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Straps and outputs
    input wire [2:0]  win_size_pin,
    input wire [7:0]  win_base_pin,
    input wire [7:0]  vector_pin,
    input wire [2:0]  far_size,
    input wire [15:0] vector_out,
    input wire [15:0] local_buf,
    input wire [15:0] disp_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Completed read strobe
    wire rd_done = pready && psel && penable && !pwrite;

    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_err_ready: assert property (pslverr |-> pready && !$past(pready))
        else $error("pslverr outside access");
    chk_base_read: assert property (rd_done && paddr == `OFF_BASE |->
        prdata == {16'h0000, win_base_pin, 8'h00}) else $error("base read");
    chk_vec_read: assert property (rd_done && paddr == `OFF_VECTOR |->
        prdata == {22'h0, vector_pin, 2'h0}) else $error("vector read");
    chk_disp_read: assert property (rd_done && paddr == `OFF_DISP |->
        prdata[15:0] == disp_out) else $error("disp read");
    chk_buf_read: assert property (rd_done && paddr == `OFF_OUT_BUF |->
        prdata[15:0] == local_buf) else $error("buffer read");
    chk_reloc_low: assert property (rd_done && paddr == `OFF_RELOC |->
        (prdata[15:0] & ((16'h0100 << far_size) - 16'h0001)) == 16'h0)
        else $error("reloc low bits");
    chk_disp_width: assert property ((disp_out >> (10 + win_size_pin)) == 0)
        else $error("disp too wide");
    chk_vec_out: assert property (vector_out == 16'h0 ||
        vector_out == {6'h0, vector_pin, 2'h0}) else $error("vector out");
    chk_init_clear: assert property ($rose(rst_n) |->
        local_buf == 16'h0 && disp_out == 16'h0) else $error("init clear");

    cov_base: cover property (rd_done && paddr == `OFF_BASE);
    cov_err: cover property (pslverr);
    cov_disp: cover property (disp_out != 16'h0000);
endmodule // window_port_monitor

bind window_port_regs window_port_monitor i_mon (.mclk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .win_size_pin,
    .win_base_pin, .vector_pin, .far_size, .vector_out, .local_buf,
    .disp_out);

// ==== test/tb_window_port_regs.sv ====
// Testbench for the window port register set
`timescale 1ns/1ps
`include "window_port_map.vh"
module tb_window_port_regs;
    reg         mclk, rst_n, psel, penable, pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, irq;
    reg  [17:0] orig_addr;
    reg         orig_valid, orig_write, orig_byte, access_error;
    reg  [15:0] orig_wdata, msg_data, disp_data;
    reg  [2:0]  win_sz;
    reg         target_master, intr_cycle, load_msg, load_disp, err;
    wire [15:0] far_buf, far_disp, vector_out, local_buf, disp_out;
    wire [17:0] target_addr;
    wire [2:0]  far_size;
    integer     miscompares, n_checks, n;

    // Device under test, 2K window based at 0x05000
    window_port_regs i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .win_size_pin(win_sz), .win_base_pin(8'h14), .vector_pin(8'h5b),
        .orig_addr(orig_addr), .orig_valid(orig_valid),
        .orig_write(orig_write), .orig_byte(orig_byte),
        .orig_wdata(orig_wdata), .access_error(access_error),
        .far_buf(far_buf), .far_disp(far_disp), .far_size(far_size),
        .target_master(target_master), .intr_cycle(intr_cycle),
        .target_addr(target_addr), .vector_out(vector_out),
        .local_buf(local_buf), .disp_out(disp_out), .irq(irq));
    far_port_model #(.FAR_SIZE(3'h2)) i_far (.mclk(mclk), .rst_n(rst_n),
        .load_msg(load_msg), .msg_data(msg_data), .load_disp(load_disp),
        .disp_data(disp_data), .far_buf(far_buf), .far_disp(far_disp),
        .far_size(far_size));

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task chk(input [8*12-1:0] name, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    // One APB transfer; request held until pready is sampled
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            n = 0;
            @(posedge mclk);
            while (pready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge mclk);
            end
            if (n == 50) begin
                miscompares = miscompares + 1;
                final_report;
            end
            rd = prdata; err = pslverr;
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask

    task rdchk(input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk("read", exp, rd);
        end
    endtask

    // Originator window cycle, pins held well past the sync delay
    task win(input [17:0] a, input [15:0] d, input e, input b);
        begin
            @(posedge mclk);
            orig_addr <= a; orig_wdata <= d; orig_valid <= 1'b1;
            orig_write <= 1'b1; access_error <= e; orig_byte <= b;
            repeat (8) @(posedge mclk);
            orig_valid <= 1'b0; access_error <= 1'b0;
            repeat (8) @(posedge mclk);
        end
    endtask

    task t_reset_vals;
        begin
            rdchk(`OFF_OUT_BUF, 32'h0);
            rdchk(`OFF_DISP, 32'h0);
            rdchk(`OFF_RELOC, 32'h0);
            rdchk(`OFF_BASE, 32'h1400);
            rdchk(`OFF_VECTOR, 32'h016c);
            apb(1'b0, 12'h028, 32'h0);
            chk("unmapped", 32'h1, {31'h0, err});
        end
    endtask

    // Message word both ways while pass-through is off
    task t_message;
        begin
            apb(1'b1, `OFF_OUT_BUF, 32'h1234);
            rdchk(`OFF_OUT_BUF, 32'h1234);
            chk("local_buf", 32'h1234, {16'h0, local_buf});
            @(posedge mclk);
            msg_data <= 16'hbeef; load_msg <= 1'b1;
            @(posedge mclk);
            load_msg <= 1'b0;
            repeat (4) @(posedge mclk);
            apb(1'b1, `OFF_IN_BUF, 32'h0);
            rdchk(`OFF_IN_BUF, 32'hbeef);
        end
    endtask

    // Relocation field and target address
    task t_reloc;
        begin
            apb(1'b1, `OFF_RELOC, 32'hffff);
            rdchk(`OFF_RELOC, 32'hfc00);
            @(posedge mclk);
            disp_data <= 16'h0abc; load_disp <= 1'b1; target_master <= 1'b1;
            @(posedge mclk);
            load_disp <= 1'b0;
            repeat (8) @(posedge mclk);
            chk("target", 32'h3fabc, {14'h0, target_addr});
            target_master <= 1'b0;
        end
    endtask

    // Window capture, interrupt, miss, error block and recovery
    task t_window;
        begin
            apb(1'b0, `OFF_STATUS, 32'h0);
            apb(1'b1, `OFF_MASK, 32'h1);
            apb(1'b1, `OFF_CTRL, 32'h3);
            win(18'h055a6, 16'h1357, 1'b0, 1'b0);
            chk("disp", 32'h05a6, {16'h0, disp_out});
            chk("irq set", 32'h1, {31'h0, irq});
            rdchk(`OFF_STATUS, 32'h1);
            @(posedge mclk);
            chk("irq clear", 32'h0, {31'h0, irq});
            apb(1'b1, `OFF_OUT_BUF, 32'hffff);
            rdchk(`OFF_OUT_BUF, 32'h1357);
            win(18'h3f5a6, 16'h2222, 1'b0, 1'b0);
            chk("miss", 32'h05a6, {16'h0, disp_out});
            win(18'h05111, 16'h0, 1'b1, 1'b0);
            chk("err disp", 32'h0111, {16'h0, disp_out});
            win(18'h05222, 16'h0, 1'b0, 1'b0);
            chk("blocked", 32'h0111, {16'h0, disp_out});
            apb(1'b0, `OFF_CTRL, 32'h0);
            chk("ctrl blk", 32'h1, {31'h0, rd[2]});
            apb(1'b1, `OFF_CTRL, 32'h7);
            win(18'h05333, 16'h0044, 1'b0, 1'b1);
            chk("reopen", 32'h0333, {16'h0, disp_out});
            rdchk(`OFF_OUT_BUF, 32'h0044);
        end
    endtask

    // Half-K window: narrower compare, relocation still follows far size
    task t_half_window;
        begin
            win_sz <= 3'h0;
            repeat (4) @(posedge mclk);
            apb(1'b1, `OFF_RELOC, 32'hffff);
            rdchk(`OFF_RELOC, 32'hfc00);
            apb(1'b1, `OFF_CTRL, 32'h3);
            win(18'h05523, 16'h0055, 1'b0, 1'b0);
            chk("half miss", 32'h0, {16'h0, disp_out});
            win(18'h05123, 16'h0066, 1'b0, 1'b0);
            chk("half disp", 32'h0123, {16'h0, disp_out});
            rdchk(`OFF_OUT_BUF, 32'h0066);
        end
    endtask

    // Vector on the interrupt cycle, then a second init
    task t_vector_init;
        begin
            intr_cycle <= 1'b1;
            n = 0;
            while (vector_out !== 16'h016c && n < 20) begin
                n = n + 1;
                @(posedge mclk);
            end
            chk("vector", 32'h016c, {16'h0, vector_out});
            intr_cycle <= 1'b0;
            rst_n <= 1'b0;
            repeat (3) @(posedge mclk);
            rst_n <= 1'b1;
            @(posedge mclk);
            chk("init buf", 32'h0, {16'h0, local_buf});
            rdchk(`OFF_RELOC, 32'h0);
            rdchk(`OFF_DISP, 32'h0);
        end
    endtask

    // Main sequence
    initial begin
        miscompares = 0; n_checks = 0;
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; orig_addr = 18'h0;
        orig_valid = 1'b0; orig_write = 1'b0; orig_byte = 1'b0;
        orig_wdata = 16'h0; access_error = 1'b0; target_master = 1'b0;
        intr_cycle = 1'b0; load_msg = 1'b0; load_disp = 1'b0;
        msg_data = 16'h0; disp_data = 16'h0; win_sz = 3'h2;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_vals;
        t_message;
        t_reloc;
        t_window;
        t_vector_init;
        t_half_window;
        final_report;
    end
endmodule // tb_window_port_regs
